// *** src/lpm_controller.sv ***
// low-power mode controller: sleep, stop and standby sequencing with wake timing
//
// The register offsets and the address-and-strobe port were left to the implementer.

// Function
// - sleep stops only processor clock, any event wakes
// - sleep wake within 6 processor cycles
// - sleep with flash powered down: 50 cycles
// - stop gates core clocks, pll, oscillators off
// - stop regulator main or low-power, normal/under-drive
// - enabled external interrupt lines end stop
// - stop normal wake: 15 us main, 28 low-power
// - stop flash powered down: 115 / 120 us
// - stop under-drive wake: 140 / 128 us
// - standby turns regulator, core, clocks off
// - standby exits on reset, watchdog, wake pin, rtc
// - no standby while regulator bypassed
// - standby wake within 400 us
// - backup domain moves to battery without main supply
module lpm_controller #(
  parameter int unsigned stop_mr_limit = lpm_pkg::stop_mr_cyc,
  parameter int unsigned stop_lpr_limit = lpm_pkg::stop_lpr_cyc,
  parameter int unsigned stop_mr_fdp_limit = lpm_pkg::stop_mr_fdp_cyc,
  parameter int unsigned stop_lpr_fdp_limit = lpm_pkg::stop_lpr_fdp_cyc,
  parameter int unsigned stop_mr_ud_limit = lpm_pkg::stop_mr_ud_cyc,
  parameter int unsigned stop_lpr_ud_limit = lpm_pkg::stop_lpr_ud_cyc,
  parameter int unsigned standby_limit = lpm_pkg::standby_cyc,
  parameter int unsigned osc_settle = lpm_pkg::osc_settle_cyc,
  parameter int unsigned reg_ud_settle = lpm_pkg::reg_ud_settle_cyc,
  parameter int unsigned fdp_settle = lpm_pkg::fdp_settle_cyc,
  parameter int unsigned reset_seq = lpm_pkg::reset_seq_cyc
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // wake sources
  input wire logic cpu_event,
  input wire lpm_pkg::lpm_wake_src_type wake_src,
  input wire logic reset_pin_n,
  input wire logic independent_watchdog,
  input wire logic wake_pin,
  input wire logic rtc_standby_event,
  // supply status
  input wire logic regulator_bypass,
  input wire logic main_supply_ok,
  // power and clock controls
  output lpm_pkg::lpm_power_ctl_type power_ctl,
  output logic backup_on_battery,
  output logic cpu_fetch_en
);

  lpm_pkg::lpm_state_type state;
  lpm_pkg::lpm_state_type next_state;
  logic [31:0] ctrl;
  logic [31:0] line_en;
  logic [lpm_pkg::irq_w-1:0] irq_status;
  logic [lpm_pkg::irq_w-1:0] irq_mask;
  logic [lpm_pkg::irq_w-1:0] irq_set;
  logic [1:0] wake_from;
  logic wake_pin_q;
  logic stop_wake;
  logic standby_wake;
  logic [lpm_pkg::cnt_w-1:0] wake_load;
  logic timer_load;
  logic timer_done;
  logic timer_running;
  logic [31:0] rd_mux;
  logic cmd_wr;
  logic [1:0] cmd;

  assign cmd_wr = reg_wr && (reg_addr == lpm_pkg::reg_cmd);
  assign cmd = reg_wdata[1:0];

  // enabled lines only; the 16 external lines plus internal sources
  always_comb
  begin
    stop_wake = |(wake_src.external_interrupt_line & line_en[lpm_pkg::ext_lines-1:0]);
    stop_wake = stop_wake
      || (wake_src.voltage_detector_output && line_en[lpm_pkg::en_vdet_bit])
      || (wake_src.rtc_event && line_en[lpm_pkg::en_rtc_bit])
      || (wake_src.usb_wake && line_en[lpm_pkg::en_usb_bit]);
  end

  // rising edge only on the wake pin; other sources are levels or pulses
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      wake_pin_q <= 1'b0;
    else
      wake_pin_q <= wake_pin;
  end

  assign standby_wake = !reset_pin_n || independent_watchdog
    || (wake_pin && !wake_pin_q) || rtc_standby_event;

  // each wake phase is given a settle time well inside its latency limit
  always_comb
  begin
    wake_load = lpm_pkg::cnt_w'(lpm_pkg::sleep_resume_cyc);
    if (state == lpm_pkg::lpm_sleep && ctrl[lpm_pkg::ctrl_fdp_bit])
      wake_load = lpm_pkg::cnt_w'(lpm_pkg::flash_wake_cyc);
    else if (state == lpm_pkg::lpm_stop)
    begin
      if (ctrl[lpm_pkg::ctrl_ud_bit])
        wake_load = lpm_pkg::cnt_w'(reg_ud_settle);
      else if (ctrl[lpm_pkg::ctrl_fdp_bit])
        wake_load = lpm_pkg::cnt_w'(fdp_settle);
      else
        wake_load = lpm_pkg::cnt_w'(osc_settle);
    end
    else if (state == lpm_pkg::lpm_standby)
      wake_load = lpm_pkg::cnt_w'(reset_seq);
  end

  always_comb
  begin
    next_state = state;
    timer_load = 1'b0;
    case (state)
      lpm_pkg::lpm_run:
        if (cmd_wr && cmd == lpm_pkg::cmd_sleep)
          next_state = lpm_pkg::lpm_sleep;
        else if (cmd_wr && cmd == lpm_pkg::cmd_stop)
          next_state = lpm_pkg::lpm_stop;
        else if (cmd_wr && cmd == lpm_pkg::cmd_standby && !regulator_bypass)
          next_state = lpm_pkg::lpm_standby;
      lpm_pkg::lpm_sleep:
        if (cpu_event || stop_wake)
        begin
          next_state = lpm_pkg::lpm_wake;
          timer_load = 1'b1;
        end
      lpm_pkg::lpm_stop:
        if (stop_wake)
        begin
          next_state = lpm_pkg::lpm_wake;
          timer_load = 1'b1;
        end
      lpm_pkg::lpm_standby:
        if (standby_wake)
        begin
          next_state = lpm_pkg::lpm_reset_seq;
          timer_load = 1'b1;
        end
      lpm_pkg::lpm_wake,
      lpm_pkg::lpm_reset_seq:
        if (timer_done)
          next_state = lpm_pkg::lpm_run;
      default:
        next_state = lpm_pkg::lpm_run;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      state <= lpm_pkg::lpm_run;
    else
      state <= next_state;
  end

  // remember which mode the wake came from for the interrupt report
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      wake_from <= 2'h0;
    else if (timer_load)
      wake_from <= (state == lpm_pkg::lpm_sleep) ? lpm_pkg::cmd_sleep
        : (state == lpm_pkg::lpm_stop) ? lpm_pkg::cmd_stop : lpm_pkg::cmd_standby;
  end

  lpm_wake_timer #(
    .width(lpm_pkg::cnt_w)
  ) u_wake_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .load(timer_load),
    .load_value(wake_load),
    .running(timer_running),
    .done(timer_done)
  );

  // power controls follow the state; the core keeps power in stop (retention)
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      power_ctl <= '{cpu_clk_en: 1'b1, core_clk_en: 1'b1, pll_en: 1'b1,
        internal_rc_oscillator_en: 1'b1, external_crystal_oscillator_en: 1'b1,
        regulator_on: 1'b1, low_power_regulator_sel: 1'b0, under_drive: 1'b0,
        flash_deep_pd: 1'b0, core_reset_n: 1'b1};
    end
    else
    begin
      power_ctl.cpu_clk_en <= (next_state == lpm_pkg::lpm_run);
      power_ctl.core_clk_en <= (next_state != lpm_pkg::lpm_stop)
        && (next_state != lpm_pkg::lpm_standby);
      power_ctl.pll_en <= (next_state != lpm_pkg::lpm_stop)
        && (next_state != lpm_pkg::lpm_standby);
      power_ctl.internal_rc_oscillator_en <= (next_state != lpm_pkg::lpm_stop)
        && (next_state != lpm_pkg::lpm_standby);
      power_ctl.external_crystal_oscillator_en <= (next_state != lpm_pkg::lpm_stop)
        && (next_state != lpm_pkg::lpm_standby);
      power_ctl.regulator_on <= (next_state != lpm_pkg::lpm_standby);
      power_ctl.low_power_regulator_sel <= (next_state == lpm_pkg::lpm_stop)
        && ctrl[lpm_pkg::ctrl_lpr_bit];
      power_ctl.under_drive <= (next_state == lpm_pkg::lpm_stop)
        && ctrl[lpm_pkg::ctrl_ud_bit];
      // under-drive forces the flash into deep power-down
      power_ctl.flash_deep_pd <= ((next_state == lpm_pkg::lpm_sleep)
        || (next_state == lpm_pkg::lpm_stop))
        && (ctrl[lpm_pkg::ctrl_fdp_bit] || (next_state == lpm_pkg::lpm_stop
        && ctrl[lpm_pkg::ctrl_ud_bit]));
      power_ctl.core_reset_n <= (next_state != lpm_pkg::lpm_standby)
        && (next_state != lpm_pkg::lpm_reset_seq);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      cpu_fetch_en <= 1'b1;
    else
      cpu_fetch_en <= (next_state == lpm_pkg::lpm_run);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      backup_on_battery <= 1'b0;
    else
      backup_on_battery <= !main_supply_ok;
  end

  // configuration registers; core-domain state is lost in standby
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || state == lpm_pkg::lpm_reset_seq)
    begin
      ctrl <= lpm_pkg::ctrl_reset;
      line_en <= lpm_pkg::line_en_reset;
      irq_mask <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == lpm_pkg::reg_ctrl)
        ctrl <= reg_wdata & 32'h0000_0007;
      if (reg_addr == lpm_pkg::reg_line_en)
        line_en <= reg_wdata & 32'h0007_ffff;
      if (reg_addr == lpm_pkg::reg_irq_mask)
        irq_mask <= reg_wdata[lpm_pkg::irq_w-1:0];
    end
  end

  always_comb
  begin
    irq_set = '0;
    irq_set[lpm_pkg::irq_wake_sleep] = timer_done && wake_from == lpm_pkg::cmd_sleep;
    irq_set[lpm_pkg::irq_wake_stop] = timer_done && wake_from == lpm_pkg::cmd_stop;
    irq_set[lpm_pkg::irq_wake_standby] = timer_done && wake_from == lpm_pkg::cmd_standby;
    irq_set[lpm_pkg::irq_standby_refused] = cmd_wr && cmd == lpm_pkg::cmd_standby
      && regulator_bypass && state == lpm_pkg::lpm_run;
  end

  // read clears status, but a set in the same cycle wins
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      irq_status <= '0;
    else if (reg_rd && reg_addr == lpm_pkg::reg_irq_status)
      irq_status <= irq_set;
    else
      irq_status <= irq_status | irq_set;
  end

  assign irq = |(irq_status & irq_mask);

  always_comb
  begin
    case (reg_addr)
      lpm_pkg::reg_ctrl: rd_mux = ctrl;
      lpm_pkg::reg_status: rd_mux = {25'h0, backup_on_battery, timer_running,
        regulator_bypass, 1'b0, state};
      lpm_pkg::reg_line_en: rd_mux = line_en;
      lpm_pkg::reg_irq_status: rd_mux = {28'h0, irq_status};
      lpm_pkg::reg_irq_mask: rd_mux = {28'h0, irq_mask};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= 32'h0000_0000;
  end

endmodule : lpm_controller

// *** shared/lpm_pkg.sv ***
// package for the low-power mode controller: constants, types, register map
package lpm_pkg;

  localparam int unsigned clk_mhz = 40;
  // wake latency limits, in processor clock cycles (sleep) and us (stop/standby)
  localparam int unsigned sleep_wake_cyc = 6;
  localparam int unsigned sleep_flash_wake_cyc = 50;
  localparam int unsigned stop_mr_us = 15;
  localparam int unsigned stop_lpr_us = 28;
  localparam int unsigned stop_mr_fdp_us = 115;
  localparam int unsigned stop_lpr_fdp_us = 120;
  localparam int unsigned stop_mr_ud_us = 140;
  localparam int unsigned stop_lpr_ud_us = 128;
  localparam int unsigned standby_us = 400;
  // limit times convert exactly to whole cycles at clk_mhz cycles per us
  localparam int unsigned stop_mr_cyc = stop_mr_us * clk_mhz;
  localparam int unsigned stop_lpr_cyc = stop_lpr_us * clk_mhz;
  localparam int unsigned stop_mr_fdp_cyc = stop_mr_fdp_us * clk_mhz;
  localparam int unsigned stop_lpr_fdp_cyc = stop_lpr_fdp_us * clk_mhz;
  localparam int unsigned stop_mr_ud_cyc = stop_mr_ud_us * clk_mhz;
  localparam int unsigned stop_lpr_ud_cyc = stop_lpr_ud_us * clk_mhz;
  localparam int unsigned standby_cyc = standby_us * clk_mhz;
  // internal settle and reset-sequence lengths used inside the limits
  localparam int unsigned sleep_resume_cyc = 2;
  localparam int unsigned flash_wake_cyc = 40;
  localparam int unsigned osc_settle_cyc = 400;
  localparam int unsigned reg_ud_settle_cyc = 3200;
  localparam int unsigned fdp_settle_cyc = 3600;
  localparam int unsigned reset_seq_cyc = 12000;

  localparam int unsigned ext_lines = 16;
  localparam int unsigned cnt_w = 16;

  // register map (word offsets)
  localparam logic [3:0] reg_ctrl = 4'h0;
  localparam logic [3:0] reg_status = 4'h1;
  localparam logic [3:0] reg_line_en = 4'h2;
  localparam logic [3:0] reg_irq_status = 4'h3;
  localparam logic [3:0] reg_irq_mask = 4'h4;
  localparam logic [3:0] reg_cmd = 4'h5;

  // ctrl fields
  localparam int unsigned ctrl_lpr_bit = 0;
  localparam int unsigned ctrl_ud_bit = 1;
  localparam int unsigned ctrl_fdp_bit = 2;
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  // line enable: 16 external lines, then voltage detector, rtc, usb
  localparam int unsigned en_vdet_bit = 16;
  localparam int unsigned en_rtc_bit = 17;
  localparam int unsigned en_usb_bit = 18;
  localparam logic [31:0] line_en_reset = 32'h0000_0000;
  // cmd codes written to reg_cmd
  localparam logic [1:0] cmd_sleep = 2'h1;
  localparam logic [1:0] cmd_stop = 2'h2;
  localparam logic [1:0] cmd_standby = 2'h3;
  // interrupt status bits
  localparam int unsigned irq_w = 4;
  localparam int unsigned irq_wake_sleep = 0;
  localparam int unsigned irq_wake_stop = 1;
  localparam int unsigned irq_wake_standby = 2;
  localparam int unsigned irq_standby_refused = 3;

  typedef enum logic [2:0] {
    lpm_run, lpm_sleep, lpm_stop, lpm_standby, lpm_wake, lpm_reset_seq
  } lpm_state_type;

  typedef struct packed {
    logic cpu_clk_en;
    logic core_clk_en;
    logic pll_en;
    logic internal_rc_oscillator_en;
    logic external_crystal_oscillator_en;
    logic regulator_on;
    logic low_power_regulator_sel;
    logic under_drive;
    logic flash_deep_pd;
    logic core_reset_n;
  } lpm_power_ctl_type;

  typedef struct packed {
    logic [ext_lines-1:0] external_interrupt_line;
    logic voltage_detector_output;
    logic rtc_event;
    logic usb_wake;
  } lpm_wake_src_type;

endpackage : lpm_pkg

// *** src/lpm_wake_timer.sv ***
// down counter that times a wake-up phase and reports when it expires
module lpm_wake_timer #(
  parameter int unsigned width = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // control
  input wire logic load,
  input wire logic [width-1:0] load_value,
  // status
  output logic running,
  output logic done
);

  logic [width-1:0] count;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      count <= '0;
    else if (load)
      count <= load_value;
    else if (count != '0)
      count <= count - 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      done <= 1'b0;
    else
      done <= !load && (count == {{(width-1){1'b0}}, 1'b1});
  end

  assign running = (count != '0);

endmodule : lpm_wake_timer

// *** tb/lpm_assertions.sv ***
// checker on the low-power mode controller ports
module lpm_check (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // watched ports
  input wire logic cpu_event,
  input wire logic regulator_bypass,
  input wire logic main_supply_ok,
  input wire lpm_pkg::lpm_power_ctl_type power_ctl,
  input wire logic backup_on_battery,
  input wire logic cpu_fetch_en
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  logic cpu_off;
  logic osc_any;
  assign cpu_off = !power_ctl.cpu_clk_en && power_ctl.core_clk_en && power_ctl.pll_en;
  assign osc_any = power_ctl.pll_en || power_ctl.internal_rc_oscillator_en ||
    power_ctl.external_crystal_oscillator_en;
  property p_sleep_keep;
    $fell(power_ctl.cpu_clk_en) && power_ctl.core_clk_en |-> osc_any && power_ctl.regulator_on;
  endproperty
  a_sleep_keep: assert property (p_sleep_keep) else $error("sleep stopped too much");
  property p_sleep_wake;
    cpu_off && !power_ctl.flash_deep_pd && $rose(cpu_event) |-> ##[0:6] cpu_fetch_en;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("slow sleep wake");
  property p_sleep_fdp;
    cpu_off && power_ctl.flash_deep_pd && cpu_event |-> ##[0:50] cpu_fetch_en;
  endproperty
  a_sleep_fdp: assert property (p_sleep_fdp) else $error("slow flash sleep wake");
  property p_stop_off;
    $fell(power_ctl.core_clk_en) && power_ctl.regulator_on |-> !osc_any && !power_ctl.cpu_clk_en;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("stop left clocks on");
  property p_ud_fdp;
    $fell(power_ctl.core_clk_en) && power_ctl.under_drive |-> power_ctl.flash_deep_pd;
  endproperty
  a_ud_fdp: assert property (p_ud_fdp) else $error("under-drive with flash on");
  // past regulator state keeps the standby exit out of this window
  property p_stop_wake;
    $rose(power_ctl.pll_en) && $past(power_ctl.regulator_on) && !$past(power_ctl.under_drive) &&
      !$past(power_ctl.flash_deep_pd) && !$past(power_ctl.low_power_regulator_sel)
      |-> ##[1:600] cpu_fetch_en;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("slow stop wake");
  property p_stdby_off;
    !power_ctl.regulator_on |-> !osc_any && !power_ctl.core_clk_en && !cpu_fetch_en;
  endproperty
  a_stdby_off: assert property (p_stdby_off) else $error("standby left core on");
  property p_bypass;
    regulator_bypass && power_ctl.regulator_on |=> power_ctl.regulator_on;
  endproperty
  a_bypass: assert property (p_bypass) else $error("standby while bypassed");
  // bound suits the shortened reset sequence used in simulation
  property p_stdby_wake;
    $rose(power_ctl.regulator_on) |-> ##[1:1000] cpu_fetch_en;
  endproperty
  a_stdby_wake: assert property (p_stdby_wake) else $error("slow standby wake");
  property p_battery;
    1'b1 |=> backup_on_battery == !$past(main_supply_ok);
  endproperty
  a_battery: assert property (p_battery) else $error("backup supply wrong");
  property p_core_rst;
    $fell(power_ctl.core_reset_n) |-> (!power_ctl.core_reset_n && !cpu_fetch_en) [*8];
  endproperty
  a_core_rst: assert property (p_core_rst) else $error("short core reset");
  c_sleep: cover property ($fell(cpu_fetch_en) && power_ctl.core_clk_en);
  c_stop: cover property ($fell(power_ctl.core_clk_en) && power_ctl.regulator_on);
  c_stdby: cover property ($fell(power_ctl.regulator_on));
endmodule : lpm_check

// *** tb/lpm_src_model.sv ***
// processor event and wake-source model facing the controller
module lpm_src_model (
  // clock
  input wire logic sys_clk,
  // requests from the bench
  input wire logic fire,
  input wire logic [2:0] which,
  input wire logic [4:0] line,
  // wake sources
  output logic cpu_event,
  output lpm_pkg::lpm_wake_src_type wake_src,
  output logic reset_pin_n,
  output logic independent_watchdog,
  output logic wake_pin,
  output logic rtc_standby_event
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] hold = 2'h0;
  logic [2:0] src = 3'h0;
  logic [4:0] sel = 5'h0;
  logic on;
  // three cycles, so a level-sampled wake cannot slip between edges
  always_ff @(posedge sys_clk)
  begin
    if (fire)
    begin
      hold <= 2'h3;
      src <= which;
      sel <= line;
    end
    else if (on)
      hold <= hold - 2'h1;
  end
  assign on = hold != 2'h0;
  always_comb
  begin
    wake_src = '0;
    if (on && src == 3'h1)
      wake_src[sel] = 1'b1;
  end
  assign cpu_event = on && src == 3'h0;
  assign reset_pin_n = !(on && src == 3'h2);
  assign independent_watchdog = on && src == 3'h3;
  assign wake_pin = on && src == 3'h4;
  assign rtc_standby_event = on && src == 3'h5;
endmodule : lpm_src_model

// *** tb/test_lpm_controller.sv ***
// self-checking bench for the low-power mode controller
module test_lpm_controller;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, reset_n, reg_wr, reg_rd, irq, cpu_event, reset_pin_n, fire, saw_rst;
  logic independent_watchdog, wake_pin, rtc_standby_event, regulator_bypass;
  logic main_supply_ok, backup_on_battery, cpu_fetch_en;
  logic [2:0] which;
  logic [4:0] line;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  lpm_pkg::lpm_wake_src_type wake_src;
  lpm_pkg::lpm_power_ctl_type power_ctl;
  int n_fail, checks_done, n, b, d;
  integer seed = 32'hb68fc6a4;
  lpm_controller #(.osc_settle(8), .reg_ud_settle(12), .fdp_settle(16), .reset_seq(20)) DUT (
    .sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .cpu_event,
    .wake_src, .reset_pin_n, .independent_watchdog, .wake_pin, .rtc_standby_event,
    .regulator_bypass, .main_supply_ok, .power_ctl, .backup_on_battery, .cpu_fetch_en);
  lpm_src_model u_src (.sys_clk, .fire, .which, .line, .cpu_event, .wake_src, .reset_pin_n,
    .independent_watchdog, .wake_pin, .rtc_standby_event);
  function automatic logic [4:0] ws_bit(int x);
    return 5'(x < 16 ? x + 3 : 18 - x);
  endfunction : ws_bit
  function automatic logic [9:0] stop_pwr(logic [2:0] c);
    return {6'h01, c[0], c[1], c[2] | c[1], 1'b1};
  endfunction : stop_pwr
  function automatic int stop_lim(logic [2:0] c);
    if (c[1])
      return c[0] ? lpm_pkg::stop_lpr_ud_cyc : lpm_pkg::stop_mr_ud_cyc;
    if (c[2])
      return c[0] ? lpm_pkg::stop_lpr_fdp_cyc : lpm_pkg::stop_mr_fdp_cyc;
    return c[0] ? lpm_pkg::stop_lpr_cyc : lpm_pkg::stop_mr_cyc;
  endfunction : stop_lim
  task automatic wrap_up;
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a, logic [31:0] exp, string what);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask : rd
  task automatic mode(logic [1:0] c);
    wr(lpm_pkg::reg_cmd, {30'h0, c});
    @(posedge sys_clk);
    #1;
  endtask : mode
  task automatic kick(logic [2:0] k, logic [4:0] l);
    @(posedge sys_clk);
    fire <= 1'b1;
    which <= k;
    line <= l;
    @(posedge sys_clk);
    fire <= 1'b0;
  endtask : kick
  // counts edges from the source going high until fetch resumes
  task automatic wait_fetch;
    n = 0;
    saw_rst = 1'b0;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
      // only a reset held after power returns counts, not the standby itself
      if (power_ctl.core_reset_n !== 1'b1 && power_ctl.regulator_on === 1'b1)
        saw_rst = 1'b1;
    end
    while (cpu_fetch_en !== 1'b1 && n < 20000);
    if (n >= 20000)
    begin
      n_fail++;
      wrap_up();
    end
  endtask : wait_fetch
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    {reset_n, reg_wr, reg_rd, fire, regulator_bypass} = '0;
    {reg_addr, reg_wdata, which, line} = '0;
    main_supply_ok = 1'b1;
    n_fail = 0;
    checks_done = 0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("power_ctl", 32'h3f1, 32'(power_ctl));
    rd(lpm_pkg::reg_ctrl, 32'h0, "ctrl");
    rd(4'hf, 32'h0, "unmapped");
    wr(lpm_pkg::reg_irq_mask, 32'h1);
    for (int f = 0; f < 2; f++)
    begin
      wr(lpm_pkg::reg_ctrl, 32'(4 * f));
      mode(lpm_pkg::cmd_sleep);
      chk("sleep_clk", 32'h1, 32'(power_ctl.core_clk_en & !power_ctl.cpu_clk_en));
      kick(3'h0, 5'h0);
      wait_fetch();
      d = f ? lpm_pkg::sleep_flash_wake_cyc : lpm_pkg::sleep_wake_cyc;
      chk("sleep_lat", 32'h1, 32'(n <= d));
      chk("irq", 32'h1, 32'(irq));
      rd(lpm_pkg::reg_irq_status, 32'h1, "irq_status");
      chk("irq", 32'h0, 32'(irq));
    end
    // every regulator and flash setting, random enabled lines
    for (int c = 0; c < 8; c++)
    begin
      b = ($random(seed) & 32'h7fff_ffff) % 19;
      d = (b + 1) % 19;
      wr(lpm_pkg::reg_ctrl, 32'(c));
      wr(lpm_pkg::reg_line_en, ((32'($random(seed)) & 32'h7ffff) | 32'h1 << b) & ~(32'h1 << d));
      mode(lpm_pkg::cmd_stop);
      chk("stop_pwr", 32'(stop_pwr(3'(c))), 32'(power_ctl));
      kick(3'h1, ws_bit(d));
      repeat (20) @(posedge sys_clk);
      #1;
      chk("stop_hold", 32'h0, 32'(cpu_fetch_en));
      kick(3'h1, ws_bit(b));
      wait_fetch();
      chk("stop_lat", 32'h1, 32'(n <= stop_lim(3'(c))));
    end
    chk("irq", 32'h0, 32'(irq));
    rd(lpm_pkg::reg_irq_status, 32'h2, "irq_status");
    @(posedge sys_clk);
    regulator_bypass <= 1'b1;
    mode(lpm_pkg::cmd_standby);
    chk("bypass", 32'h1, 32'(cpu_fetch_en & power_ctl.regulator_on));
    rd(lpm_pkg::reg_irq_status, 32'h8, "irq_status");
    @(posedge sys_clk);
    regulator_bypass <= 1'b0;
    for (int k = 2; k < 6; k++)
    begin
      wr(lpm_pkg::reg_ctrl, 32'h1);
      mode(lpm_pkg::cmd_standby);
      chk("stdby_pwr", 32'h0, 32'(power_ctl[9:4]));
      kick(3'(k), 5'h0);
      wait_fetch();
      chk("stdby_lat", 32'h1, 32'(n <= lpm_pkg::standby_cyc));
      chk("core_rst", 32'h1, 32'(saw_rst));
      rd(lpm_pkg::reg_ctrl, 32'h0, "ctrl");
    end
    rd(lpm_pkg::reg_irq_status, 32'h4, "irq_status");
    for (int v = 0; v < 2; v++)
    begin
      @(posedge sys_clk);
      main_supply_ok <= 1'(v);
      repeat (2) @(posedge sys_clk);
      #1;
      chk("battery", 32'(1 - v), 32'(backup_on_battery));
    end
    wrap_up();
  end
endmodule : test_lpm_controller

bind lpm_controller lpm_check u_chk (.sys_clk, .reset_n, .cpu_event, .regulator_bypass,
  .main_supply_ok, .power_ctl, .backup_on_battery, .cpu_fetch_en);
